/* design/adc_pkg.sv */
// Package with register map, field positions, reset values and timing for the audio DMA control bank.
// Notes on behaviour
// - Playback rate field selects output sample rate from eight codes.
// - Record rate field selects input sample rate with the same code map.
// - Channel-B digital bit carries digital in and out on DMA channel B.
// - Channel-A digital bit feeds only digital output from DMA channel A.
// - External loopback drives digital input pin straight to digital output pin when clock switch code is 00 or 01.
// - Monitor bit also feeds digital output stream to the playback converter.
// - Master block interrupts pass only while the mask bit is one.
// - Bus requests from master and converter blocks blocked while gate bit is zero.
// - Legacy voice enable turns emulated voice devices on channel 0 on or off.
// - Separate bits enable legacy music port and game port.
// - Clock switch drives output pin from stream, 16.9344 MHz or 24.576 MHz clock.
// - Compressed-audio enable sets channel status bit 30 on digital output.
// - Secondary select makes the receiver take the secondary input pin.
// - Offset and synth mute both set force synth PCM output to 0002h.
// - With 24-bit and 32-bit selects set, output sends bits 23:0 only.
// - Input-invert bit inverts the received digital input data.
// - Resolution field sets sample width 16, 15, 14 or 13 bits.
// - Bit-time field sets 600 ns, 660 ns, 1.3 us or 2.8 us per bit.
// - Each channel format field selects 8/16-bit mono/stereo packing.
// - Channel hold bit written zero clears pending interrupt, one holds it.
// - Position hold bit clears or holds position interrupt independently.
// - Upper byte of format register reads a fixed sub-version code.
// - 32-bit select gives 32-bit output words (24-bit when 24-bit select is set), else 16-bit words.
package adc_pkg;
  localparam logic [7:0] ADDR_FC0 = 8'h00;
  localparam logic [7:0] ADDR_FC1 = 8'h04;
  localparam logic [7:0] ADDR_FMT = 8'h08;
  localparam logic [7:0] ADDR_IHC = 8'h0C;
  localparam logic [31:0] MASK_FC0 = 32'h000F_000F;
  localparam logic [31:0] MASK_FC1 = 32'h0000_FFFE;
  localparam logic [31:0] MASK_FMT = 32'h00DF_FF0F;
  localparam logic [31:0] MASK_IHC = 32'h0007_0000;
  localparam logic [31:0] RST_FMT = 32'h0000_2000;
  // Arbitrary sub-version value.
  localparam logic [7:0] SUB_VERSION = 8'h5A;
  localparam int VER_LSB = 24;
  localparam int PRATE_LSB = 13;
  localparam int RRATE_LSB = 10;
  localparam int B_CHANB = 9;
  localparam int B_CHANA = 8;
  localparam int B_LOOP = 7;
  localparam int B_MON = 6;
  localparam int B_IMASK = 5;
  localparam int B_BUS_REQUEST_GATE = 4;
  localparam int B_VOICE = 3;
  localparam int B_MUSIC = 2;
  localparam int B_GAME = 1;
  localparam int CLKSW_LSB = 22;
  localparam int B_COMPR = 20;
  localparam int B_SEC = 19;
  localparam int B_OFFS = 18;
  localparam int B_24 = 17;
  localparam int B_INV = 16;
  localparam int WIDTH_LSB = 14;
  localparam int BTIME_LSB = 12;
  localparam int CH1F_LSB = 2;
  localparam int CH0F_LSB = 0;
  localparam int B_POSH = 18;
  localparam int B_CH1H = 17;
  localparam int B_CH0H = 16;
  typedef enum logic [2:0] {
    RATE_5K512 = 3'b000, RATE_11K025 = 3'b001, RATE_22K05 = 3'b010,
    RATE_44K1 = 3'b011, RATE_8K = 3'b100, RATE_16K = 3'b101,
    RATE_32K = 3'b110, RATE_48K = 3'b111
  } adc_rate_t;
  localparam logic [4:0] MAX_BITS = 5'd16;
  localparam logic [15:0] SYNTH_DC = 16'h0002;
  localparam logic [31:0] MASK_24 = 32'h00FF_FFFF;
  localparam logic [31:0] MASK_16 = 32'h0000_FFFF;
  localparam int CLK_NS = 40;
  localparam int BT0_NS = 600;
  localparam int BT1_NS = 660;
  localparam int BT2_NS = 1300;
  localparam int BT3_NS = 2800;
  localparam logic [7:0] BT0_CYC = 8'((BT0_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] BT1_CYC = 8'((BT1_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] BT2_CYC = 8'((BT2_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] BT3_CYC = 8'((BT3_NS + CLK_NS - 1) / CLK_NS);
endpackage

/* design/adc_regs.sv */
// Register bank and data-path steering for the two audio DMA channels.
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
module adc_regs (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Events and requests from the engines
  input wire logic mcbIntEvt,
  input wire logic chan0IntEvt,
  input wire logic chan1IntEvt,
  input wire logic posIntEvt,
  input wire logic dmaBusReq,
  output logic masterIntOut,
  output logic chan0IntPend,
  output logic chan1IntPend,
  output logic posIntPend,
  output logic busRequest,
  // Configuration to the engines
  output adc_pkg::adc_rate_t playbackRate,
  output adc_pkg::adc_rate_t recordRate,
  output logic digitalIoOnChanB,
  output logic digitalOutOnChanA,
  output logic voiceEnable,
  output logic musicPortEnable,
  output logic gamePortEnable,
  output logic [4:0] sampleBits,
  output logic [7:0] bitTimeCycles,
  output logic [1:0] chan0Format,
  output logic [1:0] chan1Format,
  output logic [2:0] chan0FrameBytes,
  output logic [2:0] chan1FrameBytes,
  output logic chanStatusBit30,
  // Digital audio path
  input wire logic txBit,
  input wire logic [31:0] txWordIn,
  input wire logic [15:0] txSample,
  input wire logic [15:0] pcmSample,
  input wire logic [15:0] synthPcm,
  input wire logic synthMute,
  input wire logic digitalOut32Sel,
  output logic [31:0] txWordOut,
  output logic [15:0] dacSample,
  output logic [15:0] synthOut,
  output logic rxBit,
  // Pins
  input wire logic digitalInPin,
  input wire logic secondaryInPin,
  input wire logic clk16Pin,
  input wire logic clk24Pin,
  output logic digitalOutPin
);
  import adc_pkg::*;

  typedef struct packed {
    logic [31:0] fc0;
    logic [31:0] fc1;
    logic [31:0] fmt;
    logic [31:0] ihc;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic [1:0] dinS;
    logic [1:0] secS;
    logic [1:0] c16S;
    logic [1:0] c24S;
    logic mInt;
    logic p0;
    logic p1;
    logic pp;
    logic bus_request_gate;
    logic [4:0] bits;
    logic [7:0] btc;
    logic [2:0] fb0;
    logic [2:0] fb1;
    logic [31:0] txw;
    logic [15:0] dac;
    logic [15:0] syn;
    logic rx;
    logic dout;
    logic cs30;
  } adc_state_t;

  adc_state_t s_r;
  adc_state_t s_nxt;
  logic rstMeta_r;
  logic rstSync_r;
  logic access;
  logic [31:0] rdMux;
  logic hit;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_r <= 1'b0;
      rstSync_r <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstSync_r <= rstMeta_r;
    end
  end

  assign access = psel && penable;

  // Unmapped offsets read zero and flag an error.
  always_comb begin
    hit = 1'b1;
    if (paddr == ADDR_FC0) begin
      rdMux = s_r.fc0;
    end else if (paddr == ADDR_FC1) begin
      rdMux = s_r.fc1;
    end else if (paddr == ADDR_FMT) begin
      rdMux = {SUB_VERSION, s_r.fmt[VER_LSB-1:0]};
    end else if (paddr == ADDR_IHC) begin
      rdMux = s_r.ihc;
    end else begin
      rdMux = '0;
      hit = 1'b0;
    end
  end

  always_comb begin
    s_nxt = s_r;
    // Answer comes one cycle into the access phase.
    s_nxt.ready = access && !s_r.ready;
    s_nxt.err = access && !s_r.ready && !hit;
    if (access && !s_r.ready) begin
      s_nxt.rdata = pwrite ? '0 : rdMux;
    end
    if (access && s_r.ready && pwrite) begin
      if (paddr == ADDR_FC0) begin
        s_nxt.fc0 = pwdata & MASK_FC0;
      end else if (paddr == ADDR_FC1) begin
        s_nxt.fc1 = pwdata & MASK_FC1;
      end else if (paddr == ADDR_FMT) begin
        s_nxt.fmt = pwdata & MASK_FMT;
      end else if (paddr == ADDR_IHC) begin
        s_nxt.ihc = pwdata & MASK_IHC;
      end
    end
    s_nxt.dinS = {s_r.dinS[0], digitalInPin};
    s_nxt.secS = {s_r.secS[0], secondaryInPin};
    s_nxt.c16S = {s_r.c16S[0], clk16Pin};
    s_nxt.c24S = {s_r.c24S[0], clk24Pin};
    s_nxt.mInt = mcbIntEvt && s_r.fc1[B_IMASK];
    s_nxt.bus_request_gate = dmaBusReq && s_r.fc1[B_BUS_REQUEST_GATE];
    // A new event wins over a clear in the same cycle.
    s_nxt.p0 = chan0IntEvt || (s_r.p0 && s_r.ihc[B_CH0H]);
    s_nxt.p1 = chan1IntEvt || (s_r.p1 && s_r.ihc[B_CH1H]);
    s_nxt.pp = posIntEvt || (s_r.pp && s_r.ihc[B_POSH]);
    s_nxt.bits = MAX_BITS - {3'b000, s_r.fmt[WIDTH_LSB+:2]};
    case (s_r.fmt[BTIME_LSB+:2])
      2'b00: s_nxt.btc = BT0_CYC;
      2'b01: s_nxt.btc = BT1_CYC;
      2'b10: s_nxt.btc = BT2_CYC;
      default: s_nxt.btc = BT3_CYC;
    endcase
    s_nxt.fb0 = 3'd1 << (2'(s_r.fmt[CH0F_LSB+1]) + 2'(s_r.fmt[CH0F_LSB]));
    s_nxt.fb1 = 3'd1 << (2'(s_r.fmt[CH1F_LSB+1]) + 2'(s_r.fmt[CH1F_LSB]));
    if (!digitalOut32Sel) begin
      s_nxt.txw = txWordIn & MASK_16;
    end else if (s_r.fmt[B_24]) begin
      s_nxt.txw = txWordIn & MASK_24;
    end else begin
      s_nxt.txw = txWordIn;
    end
    s_nxt.dac = s_r.fc1[B_MON] ? txSample : pcmSample;
    s_nxt.syn = (s_r.fmt[B_OFFS] && synthMute) ? SYNTH_DC : synthPcm;
    s_nxt.cs30 = s_r.fmt[B_COMPR];
    s_nxt.rx = (s_r.fmt[B_SEC] ? s_r.secS[1] : s_r.dinS[1])
               ^ s_r.fmt[B_INV];
    case (s_r.fmt[CLKSW_LSB+:2])
      2'b10: s_nxt.dout = s_r.c16S[1];
      2'b11: s_nxt.dout = s_r.c24S[1];
      default: s_nxt.dout = s_r.fc1[B_LOOP] ? s_r.dinS[1] : txBit;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      s_r <= '0;
      s_r.fmt <= RST_FMT;
      s_r.bits <= MAX_BITS;
      s_r.btc <= BT2_CYC;
      s_r.fb0 <= 3'd1;
      s_r.fb1 <= 3'd1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Every output is taken straight from the state register.
  assign prdata = s_r.rdata;
  assign pready = s_r.ready;
  assign pslverr = s_r.err;
  assign masterIntOut = s_r.mInt;
  assign chan0IntPend = s_r.p0;
  assign chan1IntPend = s_r.p1;
  assign posIntPend = s_r.pp;
  assign busRequest = s_r.bus_request_gate;
  assign playbackRate = adc_rate_t'(s_r.fc1[PRATE_LSB+:3]);
  assign recordRate = adc_rate_t'(s_r.fc1[RRATE_LSB+:3]);
  assign digitalIoOnChanB = s_r.fc1[B_CHANB];
  assign digitalOutOnChanA = s_r.fc1[B_CHANA];
  assign voiceEnable = s_r.fc1[B_VOICE];
  assign musicPortEnable = s_r.fc1[B_MUSIC];
  assign gamePortEnable = s_r.fc1[B_GAME];
  assign sampleBits = s_r.bits;
  assign bitTimeCycles = s_r.btc;
  assign chan0Format = s_r.fmt[CH0F_LSB+:2];
  assign chan1Format = s_r.fmt[CH1F_LSB+:2];
  assign chan0FrameBytes = s_r.fb0;
  assign chan1FrameBytes = s_r.fb1;
  assign chanStatusBit30 = s_r.cs30;
  assign txWordOut = s_r.txw;
  assign dacSample = s_r.dac;
  assign synthOut = s_r.syn;
  assign rxBit = s_r.rx;
  assign digitalOutPin = s_r.dout;

  // A masked master block never reaches the interrupt output.
  master_mask_a: assert property (
    @(posedge sys_clk) disable iff (!rstSync_r)
    !s_r.fc1[B_IMASK] |=> !masterIntOut
  ) else begin
    $error("master interrupt passed while masked");
  end

  // An unmasked event shows one cycle later.
  master_pass_a: assert property (
    @(posedge sys_clk) disable iff (!rstSync_r)
    s_r.fc1[B_IMASK] && mcbIntEvt |=> masterIntOut
  ) else begin
    $error("unmasked master interrupt lost");
  end

  // A closed gate blocks every bus request.
  bus_gate_a: assert property (
    @(posedge sys_clk) disable iff (!rstSync_r)
    !s_r.fc1[B_BUS_REQUEST_GATE] |=> !busRequest
  ) else begin
    $error("bus request passed a closed gate");
  end

  // An open gate passes the request.
  bus_pass_a: assert property (
    @(posedge sys_clk) disable iff (!rstSync_r)
    s_r.fc1[B_BUS_REQUEST_GATE] && dmaBusReq |=> busRequest
  ) else begin
    $error("bus request lost with open gate");
  end

  // A zero hold bit clears channel 0 when no event arrives.
  chan0_clear_a: assert property (
    @(posedge sys_clk) disable iff (!rstSync_r)
    !chan0IntEvt && !s_r.ihc[B_CH0H] |=> !chan0IntPend
  ) else begin
    $error("channel 0 interrupt not cleared");
  end

  // A channel 0 event always sets its pending flag.
  chan0_set_a: assert property (
    @(posedge sys_clk) disable iff (!rstSync_r)
    chan0IntEvt |=> chan0IntPend
  ) else begin
    $error("channel 0 event lost");
  end

  // A zero hold bit clears channel 1 when no event arrives.
  chan1_clear_a: assert property (
    @(posedge sys_clk) disable iff (!rstSync_r)
    !chan1IntEvt && !s_r.ihc[B_CH1H] |=> !chan1IntPend
  ) else begin
    $error("channel 1 interrupt not cleared");
  end

  // A zero hold bit clears the position interrupt when no event arrives.
  pos_clear_a: assert property (
    @(posedge sys_clk) disable iff (!rstSync_r)
    !posIntEvt && !s_r.ihc[B_POSH] |=> !posIntPend
  ) else begin
    $error("position interrupt not cleared");
  end

  // A set hold bit keeps a pending position interrupt.
  pos_hold_a: assert property (
    @(posedge sys_clk) disable iff (!rstSync_r)
    posIntPend && s_r.ihc[B_POSH] |=> posIntPend
  ) else begin
    $error("position interrupt not held");
  end

  // Offset with mute forces the fixed synth value.
  synth_dc_a: assert property (
    @(posedge sys_clk) disable iff (!rstSync_r)
    s_r.fmt[B_OFFS] && synthMute |=> synthOut == SYNTH_DC
  ) else begin
    $error("synth output not forced");
  end

  // Monitoring feeds the output stream to the converter.
  monitor_dac_a: assert property (
    @(posedge sys_clk) disable iff (!rstSync_r)
    s_r.fc1[B_MON] |=> dacSample == $past(txSample)
  ) else begin
    $error("monitor stream not at converter");
  end

  // Loopback copies the synchronised input pin to the output pin.
  loop_pin_a: assert property (
    @(posedge sys_clk) disable iff (!rstSync_r)
    s_r.fc1[B_LOOP] && !s_r.fmt[CLKSW_LSB+1] |=> digitalOutPin == $past(s_r.dinS[1])
  ) else begin
    $error("loopback pin mismatch");
  end

  // Code 10 puts the slower clock on the output pin.
  clk16_pin_a: assert property (
    @(posedge sys_clk) disable iff (!rstSync_r)
    s_r.fmt[CLKSW_LSB+:2] == 2'b10 |=> digitalOutPin == $past(s_r.c16S[1])
  ) else begin
    $error("clock switch output mismatch");
  end

  // Inversion flips the primary input data.
  rx_invert_a: assert property (
    @(posedge sys_clk) disable iff (!rstSync_r)
    s_r.fmt[B_INV] && !s_r.fmt[B_SEC] |=> rxBit == !$past(s_r.dinS[1])
  ) else begin
    $error("received data not inverted");
  end

  // A hold register write keeps only its defined bits.
  hold_write_a: assert property (
    @(posedge sys_clk) disable iff (!rstSync_r)
    psel && penable && pready && pwrite && paddr == ADDR_IHC
    |=> s_r.ihc == ($past(pwdata) & MASK_IHC)
  ) else begin
    $error("hold register write wrong");
  end

  // A format register write keeps only its defined bits.
  format_write_a: assert property (
    @(posedge sys_clk) disable iff (!rstSync_r)
    psel && penable && pready && pwrite && paddr == ADDR_FMT
    |=> s_r.fmt == ($past(pwdata) & MASK_FMT)
  ) else begin
    $error("format register write wrong");
  end

  // The format register read shows the fixed code in its top byte.
  version_read_a: assert property (
    @(posedge sys_clk) disable iff (!rstSync_r)
    psel && penable && pready && !pwrite && paddr == ADDR_FMT |-> prdata[31:24] == SUB_VERSION
  ) else begin
    $error("sub-version code wrong");
  end
endmodule

/* verif/adc_host.sv */
// Host-side APB master model that reaches the register bank.
`timescale 1ns/1ps
module adc_host (
  // Clock
  input wire logic sys_clk,
  // APB master
  input wire logic pready,
  input wire logic [31:0] prdata,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

/* verif/tb_top.sv */
// Self-checking bench for the audio DMA control register bank.
`timescale 1ns/1ps
module tb_top;
  import adc_pkg::*;
  logic sys_clk = 1'b0, rst_n = 1'b0, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, bitTimeCycles;
  logic [31:0] pwdata, prdata, txWordOut, q, txWordIn = 32'h0000_0000;
  logic mcbIntEvt = 1'b0, chan0IntEvt = 1'b0, chan1IntEvt = 1'b0, posIntEvt = 1'b0;
  logic dmaBusReq = 1'b0, txBit = 1'b0, synthMute = 1'b0, digitalInPin = 1'b0;
  logic secondaryInPin = 1'b0, clk16Pin = 1'b0, clk24Pin = 1'b0, digitalOut32Sel = 1'b1;
  logic [15:0] txSample = 16'h0000, pcmSample = 16'h0000, synthPcm = 16'h1234;
  logic [15:0] dacSample, synthOut;
  logic masterIntOut, chan0IntPend, chan1IntPend, posIntPend, busRequest, rxBit;
  logic digitalIoOnChanB, digitalOutOnChanA, voiceEnable, musicPortEnable, gamePortEnable;
  logic chanStatusBit30, digitalOutPin;
  logic [4:0] sampleBits;
  logic [1:0] chan0Format, chan1Format;
  logic [2:0] chan0FrameBytes, chan1FrameBytes;
  adc_rate_t playbackRate, recordRate;
  int mismatches = 0, testsRun = 0;
  int bt[4] = '{600, 660, 1300, 2800};
  always #20 sys_clk = ~sys_clk;
  adc_host u_adc_host (.sys_clk, .pready, .prdata, .psel, .penable, .pwrite, .paddr, .pwdata);
  adc_regs u_adc_regs (.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .mcbIntEvt, .chan0IntEvt, .chan1IntEvt, .posIntEvt, .dmaBusReq,
    .masterIntOut, .chan0IntPend, .chan1IntPend, .posIntPend, .busRequest, .playbackRate,
    .recordRate, .digitalIoOnChanB, .digitalOutOnChanA, .voiceEnable, .musicPortEnable,
    .gamePortEnable, .sampleBits, .bitTimeCycles, .chan0Format, .chan1Format,
    .chan0FrameBytes, .chan1FrameBytes, .chanStatusBit30, .txBit, .txWordIn, .txSample,
    .pcmSample, .synthPcm, .synthMute, .digitalOut32Sel, .txWordOut, .dacSample, .synthOut, .rxBit,
    .digitalInPin, .secondaryInPin, .clk16Pin, .clk24Pin, .digitalOutPin);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_adc_host.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a);
    u_adc_host.xfer(1'b0, a, 32'h0000_0000, q);
  endtask
  task automatic settle;
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic t_reset;
    dmaBusReq <= 1'b1;
    mcbIntEvt <= 1'b1;
    rd(ADDR_FC1);
    chk(q, 32'h0000_0000);
    chk({busRequest, masterIntOut}, 2'b00);
    rd(ADDR_FMT);
    chk(q, {SUB_VERSION, 24'h00_2000});
    rd(8'h40);
    chk(q, 32'h0000_0000);
    chk(pslverr, 1'b1);
    $display("reset test done");
  endtask
  task automatic t_ctrl;
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_FC1, (32'(i) << PRATE_LSB) | (32'(7 - i) << RRATE_LSB));
      settle();
      chk(playbackRate, i);
      chk(recordRate, 7 - i);
    end
    wr(ADDR_FC1, 32'hFFFF_FFFF);
    rd(ADDR_FC1);
    chk(q, MASK_FC1);
    chk({digitalIoOnChanB, digitalOutOnChanA, voiceEnable, musicPortEnable}, 4'hF);
    chk({gamePortEnable, busRequest, masterIntOut}, 3'b111);
    wr(ADDR_FC1, 32'h0000_0000);
    settle();
    chk({digitalIoOnChanB, digitalOutOnChanA, voiceEnable, gamePortEnable}, 4'h0);
    chk({musicPortEnable, busRequest, masterIntOut}, 3'b000);
    $display("control test done");
  endtask
  task automatic t_fmt;
    wr(ADDR_FMT, 32'hFFFF_FFFF);
    rd(ADDR_FMT);
    chk(q, {SUB_VERSION, 24'hDF_FF0F});
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_FMT, (32'(i) << WIDTH_LSB) | (32'(i) << BTIME_LSB) | 32'(i) | (32'(3 - i) << 2));
      settle();
      chk(sampleBits, 16 - i);
      chk(bitTimeCycles, (bt[i] + 39) / 40);
      chk({chan0Format, chan1Format}, {2'(i), 2'(3 - i)});
      chk(chan0FrameBytes, (i % 2 + 1) * (i / 2 + 1));
      chk(chan1FrameBytes, ((3 - i) % 2 + 1) * ((3 - i) / 2 + 1));
    end
    $display("format test done");
  endtask
  task automatic t_path;
    txWordIn <= 32'hA5C3_9E71;
    txBit <= 1'b1;
    synthMute <= 1'b1;
    clk16Pin <= 1'b1;
    digitalInPin <= 1'b1;
    txSample <= 16'h5A5A;
    wr(ADDR_FMT, 32'h0097_0000);
    settle();
    chk(txWordOut, 32'h00C3_9E71);
    chk(dacSample, 16'h0000);
    digitalOut32Sel <= 1'b0;
    settle();
    chk(txWordOut, 32'h0000_9E71);
    digitalOut32Sel <= 1'b1;
    chk({synthOut, chanStatusBit30, digitalOutPin, rxBit}, {SYNTH_DC, 3'b110});
    wr(ADDR_FMT, 32'h00C8_0000);
    settle();
    chk({synthOut, chanStatusBit30, digitalOutPin, rxBit}, {16'h1234, 3'b000});
    wr(ADDR_FMT, 32'h0000_0000);
    txBit <= 1'b0;
    wr(ADDR_FC1, 32'h0000_00C0);
    settle();
    chk({digitalOutPin, rxBit}, 2'b11);
    chk(dacSample, 16'h5A5A);
    $display("path test done");
  endtask
  task automatic t_int;
    wr(ADDR_IHC, 32'h0007_0000);
    chan0IntEvt <= 1'b1;
    posIntEvt <= 1'b1;
    @(posedge sys_clk);
    chan0IntEvt <= 1'b0;
    posIntEvt <= 1'b0;
    settle();
    chk({chan0IntPend, chan1IntPend, posIntPend}, 3'b101);
    wr(ADDR_IHC, 32'hFFF4_FFFF);
    settle();
    chk({chan0IntPend, chan1IntPend, posIntPend}, 3'b001);
    rd(ADDR_IHC);
    chk(q, 32'h0004_0000);
    wr(ADDR_IHC, 32'h0000_0000);
    settle();
    chk(posIntPend, 1'b0);
    $display("interrupt test done");
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", testsRun, mismatches);
    if (mismatches == 0 && testsRun > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    final_report();
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    t_reset();
    t_ctrl();
    t_fmt();
    t_path();
    t_int();
    final_report();
  end
endmodule
